// >>> capture_defs.svh
// Constants for the four-channel input capture block.
// Assumes a 32-bit AHB-Lite bus, one register per aligned word.
// Summary of operation
// - Flags bits 0..3 for channels A..D; hardware sets, software only clears.
// - Flag interrupts only with channel enable and array enable both 1.
// - Compare-select 0 means capture mode, 1 means compare mode.
// - Capture copies the full 16-bit timer count and sets the flag.
// - Timer-clear bit set makes a channel event clear the timer to 0000H.
// - Pin captures are edge-triggered: falling, rising or either edge.
// - Pins sampled every cycle; source holds each level two cycles at least.
// - No overrun guard: new capture overwrites unread data.
// - Internal triggers: two timer overflows and comparator A or B events.
// - DAC blocks C/D pin captures; external memory blocks all pin captures.
// - Captures occur in any timer mode; overflow flag stays with the timer.
// - Dual-slope mode: each event latches direction, up 0, down 1.
// - Software writes to the direction bit have no effect.
// - Mode 000 disables capture; 001 captures on a falling pin edge.
// - 010 rising, 011 either, 100/101 overflows, 110/111 comparators.
// - Two-bit index selects the channel seen at control and data registers.
// - Data writes to a channel in capture mode are ignored.
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH
`define CAP_IDX_CHAN 8'hd1
`define CAP_IDX_HIGH 8'hd2
`define CAP_IDX_LOW 8'hd3
`define CAP_IDX_CTL 8'hd4
`define CAP_IDX_FLAG 8'hd5
`define CAP_IDX_ENA 8'hd6
`define CAP_CTL_RST 8'h00
`define CAP_CTL_WMASK 8'h9f
`define CAP_FLAG_RST 4'h0
`define CAP_DATA_RST 16'h0000
`define CAP_TMR_ZERO 16'h0000
`define CAP_ADDR_HI_ZERO 22'h000000
`endif

// >>> capture_pkg.sv
// Types for the four-channel input capture block.
// Assumes capture_defs.svh carries the numbers.
package capture_pkg;
  typedef enum logic [2:0] {
    ACT_OFF = 3'b000,
    ACT_FALL = 3'b001,
    ACT_RISE = 3'b010,
    ACT_BOTH = 3'b011,
    ACT_OVF0 = 3'b100,
    ACT_OVF1 = 3'b101,
    ACT_CMPA = 3'b110,
    ACT_CMPB = 3'b111
  } action_t;
  typedef struct packed {
    logic channel_irq_enable;
    logic captured_count_direction;
    logic reserved;
    logic timer_clear_on_event;
    logic compare_select;
    action_t channel_action_select;
  } ctl_t;
  typedef struct packed {
    logic [15:0] count;
    logic count_down;
    logic dual_slope;
  } timer_in_t;
  typedef struct packed {
    logic ovf0;
    logic ovf1;
    logic cmp_a;
    logic cmp_b;
  } trig_in_t;
endpackage

// >>> input_capture.sv
// Four-channel input capture and compare array with AHB-Lite registers.
// Assumes the event timer, other timers and comparators run on hclk.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "capture_defs.svh"
module input_capture (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Capture pins
  input wire logic [3:0] channel_pin,
  // Event timer and internal triggers
  input wire capture_pkg::timer_in_t timer_in,
  input wire capture_pkg::trig_in_t trig_in,
  // Pin ownership
  input wire logic dac_enable,
  input wire logic ext_mem_enable,
  // Results
  output logic timer_clear,
  output logic cca_irq
);

  // Bus registers
  logic wr_q;
  logic [7:0] wr_idx_q;
  logic rd_wait_q;
  logic [7:0] rd_idx_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;

  // Software state
  logic [1:0] channel_index_q;
  logic [7:0] shadow_high_q;
  logic array_irq_enable_q;
  logic [3:0] channel_event_flags_q;
  logic [3:0] flags_d;
  capture_pkg::ctl_t ctl_q [4];
  logic [15:0] data_q [4];

  // Pin synchroniser and edges
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_lvl_q;
  logic [3:0] pin_prev_q;
  logic [3:0] pin_lvl_d;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  // Per-channel events
  logic [3:0] cap_evt;
  logic [3:0] cmp_evt;
  logic [3:0] chan_evt;
  logic [3:0] clr_req;
  logic [3:0] match_q;
  logic [3:0] match;

  logic timer_clear_q;
  logic cca_irq_q;

  // Address phase decode
  wire addr_ok = haddr[31:10] == `CAP_ADDR_HI_ZERO && haddr[1:0] == 2'h0;
  wire take = hsel && htrans[1] && hready && hreadyout_q;
  wire take_wr = take && hwrite;
  wire take_rd = take && !hwrite;
  wire [7:0] a_idx = addr_ok ? haddr[9:2] : 8'h00;
  // A read right behind a write waits one cycle to see the written value
  wire rd_stall = take_rd && wr_q;
  wire [7:0] rd_sel_idx = rd_wait_q ? rd_idx_q : a_idx;

  // Data phase write decode
  wire [7:0] wbyte = hwdata[7:0];
  wire wr_chan = wr_q && wr_idx_q == `CAP_IDX_CHAN;
  wire wr_high = wr_q && wr_idx_q == `CAP_IDX_HIGH;
  wire wr_low = wr_q && wr_idx_q == `CAP_IDX_LOW;
  wire wr_ctl = wr_q && wr_idx_q == `CAP_IDX_CTL;
  wire wr_flag = wr_q && wr_idx_q == `CAP_IDX_FLAG;
  wire wr_ena = wr_q && wr_idx_q == `CAP_IDX_ENA;

  // Selected channel view
  wire capture_pkg::ctl_t sel_ctl = ctl_q[channel_index_q];
  wire [15:0] sel_data = data_q[channel_index_q];
  wire [7:0] sel_ctl_byte = {sel_ctl[7:6], 1'b0, sel_ctl[4:0]};

  logic [7:0] rd_byte;
  always_comb begin
    case (rd_sel_idx)
      `CAP_IDX_CHAN: rd_byte = {6'h00, channel_index_q};
      `CAP_IDX_HIGH: rd_byte = sel_data[15:8];
      `CAP_IDX_LOW: rd_byte = sel_data[7:0];
      `CAP_IDX_CTL: rd_byte = sel_ctl_byte;
      `CAP_IDX_FLAG: rd_byte = {4'h0, channel_event_flags_q};
      `CAP_IDX_ENA: rd_byte = {7'h00, array_irq_enable_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus control; the slave never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wr_idx_q <= 8'h00;
      rd_wait_q <= 1'b0;
      rd_idx_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else if (ce) begin
      wr_q <= take_wr;
      wr_idx_q <= a_idx;
      rd_wait_q <= rd_stall;
      rd_idx_q <= a_idx;
      hreadyout_q <= !rd_stall;
      if ((take_rd && !wr_q) || rd_wait_q) begin
        hrdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_index_q <= 2'h0;
      shadow_high_q <= 8'h00;
      array_irq_enable_q <= 1'b0;
    end else if (ce) begin
      if (wr_chan) begin
        channel_index_q <= wbyte[1:0];
      end
      if (wr_high) begin
        shadow_high_q <= wbyte;
      end
      if (wr_ena) begin
        array_irq_enable_q <= wbyte[0];
      end
    end
  end

  // Synchroniser: stage one feeds stage two only
  always_comb begin
    pin_lvl_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));
  end
  assign pin_rise = pin_lvl_q & ~pin_prev_q;
  assign pin_fall = ~pin_lvl_q & pin_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
      pin_lvl_q <= 4'h0;
      pin_prev_q <= 4'h0;
    end else if (ce) begin
      pin_s1_q <= channel_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lvl_q <= pin_lvl_d;
      pin_prev_q <= pin_lvl_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : chan
      wire capture_pkg::ctl_t c = ctl_q[g];
      wire is_sel = channel_index_q == 2'(g);
      wire pin_ok = !(ext_mem_enable || (g >= 2 && dac_enable));
      logic trig;
      always_comb begin
        case (c.channel_action_select)
          capture_pkg::ACT_OFF: trig = 1'b0;
          capture_pkg::ACT_FALL: trig = pin_ok && pin_fall[g];
          capture_pkg::ACT_RISE: trig = pin_ok && pin_rise[g];
          capture_pkg::ACT_BOTH: trig = pin_ok && (pin_rise[g] || pin_fall[g]);
          capture_pkg::ACT_OVF0: trig = trig_in.ovf0;
          capture_pkg::ACT_OVF1: trig = trig_in.ovf1;
          capture_pkg::ACT_CMPA: trig = trig_in.cmp_a;
          capture_pkg::ACT_CMPB: trig = trig_in.cmp_b;
          default: trig = 1'b0;
        endcase
      end
      // Timer mode is not looked at, so captures run in every timer mode
      assign cap_evt[g] = !c.compare_select && trig;
      // Compare fires once per arrival at the match, not for every held count
      assign match[g] = data_q[g] == timer_in.count;
      assign cmp_evt[g] = c.compare_select && match[g] && !match_q[g];
      assign chan_evt[g] = cap_evt[g] || cmp_evt[g];
      assign clr_req[g] = chan_evt[g] && c.timer_clear_on_event;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ctl_q[g] <= `CAP_CTL_RST;
          data_q[g] <= `CAP_DATA_RST;
          match_q[g] <= 1'b0;
        end else if (ce) begin
          match_q[g] <= match[g];
          if (wr_ctl && is_sel) begin
            // Direction bit keeps its value on software writes
            ctl_q[g] <= (wbyte & `CAP_CTL_WMASK) | (ctl_q[g] & 8'h40);
          end
          if (chan_evt[g] && timer_in.dual_slope) begin
            ctl_q[g].captured_count_direction <= timer_in.count_down;
          end
          if (cap_evt[g]) begin
            data_q[g] <= timer_in.count;
          end else if (wr_low && is_sel && c.compare_select) begin
            data_q[g] <= {shadow_high_q, wbyte};
          end
        end
      end
    end
  endgenerate

  // Set wins over a clear in the same cycle
  always_comb begin
    flags_d = channel_event_flags_q;
    if (wr_flag) begin
      flags_d = wbyte[3:0] & channel_event_flags_q;
    end
    flags_d = flags_d | chan_evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_event_flags_q <= `CAP_FLAG_RST;
      timer_clear_q <= 1'b0;
      cca_irq_q <= 1'b0;
    end else if (ce) begin
      channel_event_flags_q <= flags_d;
      timer_clear_q <= |clr_req;
      cca_irq_q <= array_irq_enable_q && |(channel_event_flags_q & enables(ctl_q[0], ctl_q[1],
        ctl_q[2], ctl_q[3]));
    end
  end

  function automatic logic [3:0] enables(capture_pkg::ctl_t a, capture_pkg::ctl_t b,
                                         capture_pkg::ctl_t cc, capture_pkg::ctl_t d);
    enables = {d.channel_irq_enable, cc.channel_irq_enable, b.channel_irq_enable, a.channel_irq_enable};
  endfunction

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign timer_clear = timer_clear_q;
  assign cca_irq = cca_irq_q;

endmodule // input_capture
`default_nettype wire

// >>> capture_checker.sv
// Port-level checks for the input capture block.
// Assumes one AHB-Lite slave, hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module capture_checker (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Results
  input wire logic timer_clear,
  input wire logic cca_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take(a, w);
    hsel && htrans[1] && hready && hwrite == w && haddr == a;
  endsequence
  // Flags settle one edge after the data phase, the request one edge later
  sequence s_zero_wr(a, m);
    s_take(a, 1'b1) ##1 (hwdata[3:0] & m) == 4'h0;
  endsequence
  a_flag_clear_irq: assert property (s_zero_wr(32'h354, 4'hf) |=> ##1 !cca_irq)
    else $error("interrupt stays after flags cleared");
  a_array_off_irq: assert property (s_zero_wr(32'h358, 4'h1) |=> ##1 !cca_irq)
    else $error("interrupt stays after array enable cleared");
  a_unmapped_zero: assert property (s_take(32'h400, 1'b0) |=>
    (hreadyout && hrdata == 32'h0) or (!hreadyout ##1 hrdata == 32'h0))
    else $error("unmapped read not zero");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_wait_single: assert property ($fell(hreadyout) |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_freeze_ce: assert property (!ce |=> $stable({hrdata, hreadyout, cca_irq, timer_clear}))
    else $error("outputs moved with clock enable low");
  a_reset_quiet: assert property (disable iff (1'b0) !hresetn ##1 !hresetn |->
    hreadyout && hrdata == 32'h0 && !cca_irq && !timer_clear)
    else $error("outputs active in reset");
endmodule // capture_checker
bind input_capture capture_checker u_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hrdata, .hresp, .timer_clear, .cca_irq);
`default_nettype wire

// >>> capture_partner.sv
// Model of the capture pins, event timer and internal triggers.
// Assumes the bench commands it through its tasks.
`timescale 1ns/1ps
`default_nettype none
module capture_partner (
  // Clock and clear request
  input wire logic hclk,
  input wire logic timer_clear,
  // Toward the capture block
  output logic [3:0] channel_pin,
  output capture_pkg::timer_in_t timer_in,
  output capture_pkg::trig_in_t trig_in
);
  initial begin
    channel_pin = 4'h0;
    timer_in = '0;
    trig_in = '0;
  end
  // Count stands still so captured values are predictable
  always @(posedge hclk) if (timer_clear) timer_in.count <= 16'h0000;
  // Level held four cycles, twice the minimum
  task pin(input logic [3:0] v);
    @(posedge hclk) channel_pin <= v;
    repeat (4) @(posedge hclk);
  endtask
  // Comparator pulses are not derived from the event timer
  task pulse(input capture_pkg::trig_in_t t);
    @(posedge hclk) trig_in <= t;
    @(posedge hclk) trig_in <= '0;
  endtask
  task tmr(input capture_pkg::timer_in_t v);
    @(posedge hclk) timer_in <= v;
  endtask
endmodule // capture_partner
`default_nettype wire

// >>> tb_four_channel_input_capture.sv
// Self-checking bench for the input capture block.
// Assumes the partner model drives pins, timer and triggers.
`timescale 1ns/1ps
`default_nettype none
`include "capture_defs.svh"
module tb_four_channel_input_capture;
  typedef struct packed {logic [2:0] mode; logic [1:0] pins; logic [3:0] trig; logic hit;} row_t;
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic dac_enable = 1'b0, ext_mem_enable = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire logic hreadyout, hresp, timer_clear, cca_irq;
  wire logic [31:0] hrdata;
  wire logic [3:0] channel_pin;
  capture_pkg::timer_in_t timer_in;
  capture_pkg::trig_in_t trig_in;
  int mismatches = 0, comparisons = 0;
  row_t rows [12] = '{{3'd0, 2'b01, 4'h0, 1'b0}, {3'd1, 2'b10, 4'h0, 1'b1}, {3'd1, 2'b01, 4'h0, 1'b0},
    {3'd2, 2'b01, 4'h0, 1'b1}, {3'd2, 2'b10, 4'h0, 1'b0}, {3'd3, 2'b10, 4'h0, 1'b1},
    {3'd4, 2'b00, 4'h8, 1'b1}, {3'd4, 2'b00, 4'h4, 1'b0}, {3'd5, 2'b00, 4'h4, 1'b1},
    {3'd6, 2'b00, 4'h2, 1'b1}, {3'd7, 2'b00, 4'h1, 1'b1}, {3'd7, 2'b00, 4'h2, 1'b0}};
  always #25 hclk = ~hclk;
  input_capture dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .channel_pin, .timer_in, .trig_in,
    .dac_enable, .ext_mem_enable, .timer_clear, .cca_irq);
  capture_partner p (.hclk, .timer_clear, .channel_pin, .timer_in, .trig_in);
  task bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge hclk) {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 20'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  task irq_is(input logic v);
    repeat (2) @(posedge hclk);
    chk({31'h0, cca_irq}, {31'h0, v});
  endtask
  task test_done;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`CAP_IDX_FLAG, 32'h0);
    rdchk(`CAP_IDX_CTL, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      p.pin({3'b0, rows[i].pins[1]});
      bus(1'b1, `CAP_IDX_CTL, {29'h0, rows[i].mode});
      bus(1'b1, `CAP_IDX_FLAG, 32'h0);
      p.pin({3'b0, rows[i].pins[0]});
      p.pulse(rows[i].trig);
      rdchk(`CAP_IDX_FLAG, {31'h0, rows[i].hit});
    end
    $display("mode table done");
    bus(1'b1, `CAP_IDX_CTL, 32'hd4);
    rdchk(`CAP_IDX_CTL, 32'h94);
    p.tmr({16'h5a3c, 1'b1, 1'b1});
    p.pulse(4'h8);
    rdchk(`CAP_IDX_HIGH, 32'h5a);
    rdchk(`CAP_IDX_LOW, 32'h3c);
    chk({16'h0, timer_in.count}, 32'h0);
    rdchk(`CAP_IDX_CTL, 32'hd4);
    p.tmr({16'h1234, 1'b0, 1'b1});
    p.pulse(4'h8);
    rdchk(`CAP_IDX_LOW, 32'h34);
    rdchk(`CAP_IDX_CTL, 32'h94);
    bus(1'b1, `CAP_IDX_HIGH, 32'h77);
    bus(1'b1, `CAP_IDX_LOW, 32'h66);
    rdchk(`CAP_IDX_LOW, 32'h34);
    $display("capture data done");
    bus(1'b1, `CAP_IDX_ENA, 32'h1);
    irq_is(1'b1);
    bus(1'b1, `CAP_IDX_ENA, 32'h0);
    irq_is(1'b0);
    bus(1'b1, `CAP_IDX_ENA, 32'h1);
    bus(1'b1, `CAP_IDX_FLAG, 32'hf);
    rdchk(`CAP_IDX_FLAG, 32'h1);
    bus(1'b1, `CAP_IDX_FLAG, 32'h0);
    irq_is(1'b0);
    $display("interrupt done");
    @(posedge hclk) dac_enable <= 1'b1;
    bus(1'b1, `CAP_IDX_CHAN, 32'h2);
    bus(1'b1, `CAP_IDX_CTL, 32'h02);
    p.pin(4'h4);
    rdchk(`CAP_IDX_FLAG, 32'h0);
    bus(1'b1, `CAP_IDX_CTL, 32'h04);
    p.pulse(4'h8);
    rdchk(`CAP_IDX_FLAG, 32'h5);
    bus(1'b1, `CAP_IDX_CTL, 32'h08);
    bus(1'b1, `CAP_IDX_FLAG, 32'h0);
    bus(1'b1, `CAP_IDX_HIGH, 32'h12);
    bus(1'b1, `CAP_IDX_LOW, 32'h34);
    rdchk(`CAP_IDX_LOW, 32'h34);
    rdchk(`CAP_IDX_FLAG, 32'h0);
    p.tmr({16'h1234, 1'b0, 1'b0});
    rdchk(`CAP_IDX_FLAG, 32'h4);
    rdchk(10'h100, 32'h0);
    @(posedge hclk) ce <= 1'b0;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    $display("pin ownership done");
    test_done;
  end
endmodule // tb_four_channel_input_capture
`default_nettype wire
